// [lsm_cfg.svh]
`ifndef LSM_CFG_SVH
`define LSM_CFG_SVH

// ****************************************
// unit geometry
// ****************************************
`define LSM_SLICES    4
`define LSM_LUTS      8
`define LSM_LUT_BITS  16
`define LSM_ADDR_W    4
`define LSM_DATA_W    8

// ****************************************
// reset values
// ****************************************
`define LSM_LUT_RST   16'h0000
`define LSM_CNT_RST   8'h00
`define LSM_OUT_RST   8'h00
`define LSM_SL_RST    4'h0

`endif

// [lsm_pkg.sv]
`default_nettype none

package lsm_pkg;

   // slice operating modes
   typedef enum logic [1:0] {
      LSM_LOGIC,
      LSM_RIPPLE,
      LSM_RAM,
      LSM_ROM
   } lsm_mode_t;

   // ripple-mode operations
   typedef enum logic [2:0] {
      LSM_ADD,
      LSM_SUB,
      LSM_ADDSUB,
      LSM_UP,
      LSM_DOWN,
      LSM_CMP
   } lsm_rop_t;

   typedef struct packed {
      logic [7:0][15:0] lut;
      logic [7:0]       cnt;
      logic [7:0]       f;
      logic [3:0]       f5;
      logic [3:0]       gen;
      logic [3:0]       prop;
      logic             cout;
      logic [3:0]       ge;
      logic [3:0]       ne;
      logic [3:0]       le;
   } lsm_state_t;

endpackage

`default_nettype wire

// [lsm_function_unit.sv]
`include "lsm_cfg.svh"
`default_nettype none

module lsm_function_unit #(
   parameter bit RAM_CAPABLE = 1'b1
) (
   // clock and reset
   input  wire logic                ref_clk_in,
   input  wire logic                resetn_in,
   // configuration
   input  wire lsm_pkg::lsm_mode_t  mode_in,
   input  wire lsm_pkg::lsm_rop_t   rop_in,
   input  wire logic [3:0]          lut5_en_in,
   input  wire logic                dual_en_in,
   input  wire logic                cfg_load_in,
   input  wire logic [2:0]          cfg_sel_in,
   input  wire logic [15:0]         cfg_data_in,
   // logic mode
   input  wire logic [31:0]         lut_in_in,
   input  wire logic [3:0]          f5_sel_in,
   // ripple mode
   input  wire logic [7:0]          a_in,
   input  wire logic [7:0]          b_in,
   input  wire logic                carry_in,
   input  wire logic                add_nsub_in,
   input  wire logic                count_en_in,
   // memory modes
   input  wire logic                we_in,
   input  wire logic [3:0]          addr_in,
   input  wire logic [3:0]          rd_addr_in,
   input  wire logic [7:0]          wdata_in,
   // results
   output logic [7:0]               f_out,
   output logic [3:0]               f5_out,
   output logic [3:0]               gen_out,
   output logic [3:0]               prop_out,
   output logic                     cout_out,
   output logic [3:0]               ge_out,
   output logic [3:0]               ne_out,
   output logic [3:0]               le_out
);

   // ****************************************
   // state
   // ****************************************
   lsm_pkg::lsm_state_t st_ff;
   lsm_pkg::lsm_state_t nxt_st;

   logic       ram_wr;
   logic [8:0] add_ref;
   logic       lut0_pick;
   logic       f5_pick;
   logic       rd0_pick;

   // logic-only unit never accepts data writes
   assign ram_wr = RAM_CAPABLE && (mode_in == lsm_pkg::LSM_RAM) && we_in && !cfg_load_in;

   // ****************************************
   // next state
   // ****************************************
   always_comb
   begin
      logic [3:0] idx;
      logic [1:0] x;
      logic [1:0] y;
      logic       c;
      logic [2:0] s3;
      logic [3:0] ra;
      idx = 4'h0;
      x = 2'h0;
      y = 2'h0;
      c = 1'b0;
      s3 = 3'h0;
      ra = 4'h0;
      nxt_st = st_ff;

      // chain carry into slice 0
      unique case (rop_in)
         lsm_pkg::LSM_ADD:    c = carry_in;
         lsm_pkg::LSM_SUB:    c = 1'b1;
         lsm_pkg::LSM_ADDSUB: c = add_nsub_in ? carry_in : 1'b1;
         lsm_pkg::LSM_UP:     c = 1'b1;
         lsm_pkg::LSM_DOWN:   c = 1'b0;
         default:             c = 1'b1;
      endcase

      for (int s = 0; s < `LSM_SLICES; s++)
      begin
         // slice behaviour follows the unit mode
         unique case (mode_in)
            lsm_pkg::LSM_LOGIC:
            begin
               idx = lut_in_in[8*s +: 4];
               nxt_st.f[2*s] = st_ff.lut[2*s][idx];
               nxt_st.f[2*s+1] = st_ff.lut[2*s+1][lut_in_in[8*s+4 +: 4]];
               // fifth input picks between the two tables
               nxt_st.f5[s] = lut5_en_in[s] && (f5_sel_in[s] ? st_ff.lut[2*s+1][idx]
                                                             : st_ff.lut[2*s][idx]);
            end
            lsm_pkg::LSM_RIPPLE:
            begin
               x = a_in[2*s +: 2];
               unique case (rop_in)
                  lsm_pkg::LSM_ADD:    y = b_in[2*s +: 2];
                  lsm_pkg::LSM_ADDSUB: y = add_nsub_in ? b_in[2*s +: 2] : ~b_in[2*s +: 2];
                  lsm_pkg::LSM_UP:     y = 2'h0;
                  lsm_pkg::LSM_DOWN:   y = 2'h3;
                  default:             y = ~b_in[2*s +: 2];
               endcase
               if (rop_in == lsm_pkg::LSM_UP || rop_in == lsm_pkg::LSM_DOWN)
               begin
                  x = st_ff.cnt[2*s +: 2];
               end
               // generate ignores carry-in, propagate passes it through both bits
               nxt_st.prop[s] = (x[0] ^ y[0]) & (x[1] ^ y[1]);
               nxt_st.gen[s] = (x[1] & y[1]) | ((x[1] ^ y[1]) & x[0] & y[0]);
               s3 = {1'b0, x} + {1'b0, y} + {2'h0, c};
               c = s3[2];
               nxt_st.f[2*s +: 2] = s3[1:0];
               if (rop_in == lsm_pkg::LSM_UP || rop_in == lsm_pkg::LSM_DOWN)
               begin
                  nxt_st.f[2*s +: 2] = count_en_in ? s3[1:0] : st_ff.cnt[2*s +: 2];
                  if (count_en_in)
                  begin
                     nxt_st.cnt[2*s +: 2] = s3[1:0];
                  end
               end
               nxt_st.ge[s] = a_in[2*s +: 2] >= b_in[2*s +: 2];
               nxt_st.ne[s] = a_in[2*s +: 2] != b_in[2*s +: 2];
               nxt_st.le[s] = a_in[2*s +: 2] <= b_in[2*s +: 2];
            end
            default:
            begin
               // companion slice of a pair serves the read-only port
               ra = (mode_in == lsm_pkg::LSM_RAM && dual_en_in && s[0]) ? rd_addr_in
                                                                       : addr_in;
               nxt_st.f[2*s] = st_ff.lut[2*s][ra];
               nxt_st.f[2*s+1] = st_ff.lut[2*s+1][ra];
               if (ram_wr)
               begin
                  if (dual_en_in)
                  begin
                     // pair holds two copies; even slice data goes to both
                     nxt_st.lut[2*s][addr_in] = wdata_in[2*(s & ~1)];
                     nxt_st.lut[2*s+1][addr_in] = wdata_in[2*(s & ~1) + 1];
                  end
                  else
                  begin
                     nxt_st.lut[2*s][addr_in] = wdata_in[2*s];
                     nxt_st.lut[2*s+1][addr_in] = wdata_in[2*s+1];
                  end
               end
            end
         endcase
      end
      if (mode_in == lsm_pkg::LSM_RIPPLE)
      begin
         nxt_st.cout = c;
      end

      // configuration fill is the only path into a ROM
      if (cfg_load_in)
      begin
         nxt_st.lut[cfg_sel_in] = cfg_data_in;
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         st_ff.lut <= {`LSM_LUTS{`LSM_LUT_RST}};
         st_ff.cnt <= `LSM_CNT_RST;
         st_ff.f <= `LSM_OUT_RST;
         st_ff.f5 <= `LSM_SL_RST;
         st_ff.gen <= `LSM_SL_RST;
         st_ff.prop <= `LSM_SL_RST;
         st_ff.cout <= 1'b0;
         st_ff.ge <= `LSM_SL_RST;
         st_ff.ne <= `LSM_SL_RST;
         st_ff.le <= `LSM_SL_RST;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign f_out = st_ff.f;
   assign f5_out = st_ff.f5;
   assign gen_out = st_ff.gen;
   assign prop_out = st_ff.prop;
   assign cout_out = st_ff.cout;
   assign ge_out = st_ff.ge;
   assign ne_out = st_ff.ne;
   assign le_out = st_ff.le;

   // ****************************************
   // checks
   // ****************************************
   assign add_ref = {1'b0, a_in} + {1'b0, b_in} + {8'h00, carry_in};
   assign lut0_pick = st_ff.lut[0][lut_in_in[3:0]];
   assign f5_pick = f5_sel_in[0] ? st_ff.lut[1][lut_in_in[3:0]] : st_ff.lut[0][lut_in_in[3:0]];
   assign rd0_pick = st_ff.lut[0][addr_in];

   default clocking lsm_cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!resetn_in);

   ram_write_a: assert property (ram_wr && !dual_en_in
      |=> st_ff.lut[0][$past(addr_in)] == $past(wdata_in[0]) &&
          st_ff.lut[7][$past(addr_in)] == $past(wdata_in[7]))
      else $error("ram write did not land");
   ram_read_a: assert property ((mode_in == lsm_pkg::LSM_RAM)
      |=> f_out[0] == $past(rd0_pick))
      else $error("ram read data wrong");
   no_ram_a: assert property (!RAM_CAPABLE && !cfg_load_in |=> $stable(st_ff.lut))
      else $error("logic-only unit stored data");
   rom_hold_a: assert property ((mode_in == lsm_pkg::LSM_ROM) && !cfg_load_in
      |=> $stable(st_ff.lut))
      else $error("rom contents changed");
   lut_out_a: assert property ((mode_in == lsm_pkg::LSM_LOGIC) |=> f_out[0] == $past(lut0_pick))
      else $error("lut output wrong");
   lut5_out_a: assert property ((mode_in == lsm_pkg::LSM_LOGIC) && lut5_en_in[0]
      |=> f5_out[0] == $past(f5_pick))
      else $error("five-input output wrong");
   add_sum_a: assert property ((mode_in == lsm_pkg::LSM_RIPPLE) &&
      (rop_in == lsm_pkg::LSM_ADD) |=> {cout_out, f_out} == $past(add_ref))
      else $error("sum wrong");
   cmp_res_a: assert property ((mode_in == lsm_pkg::LSM_RIPPLE) &&
      (a_in[1:0] == b_in[1:0]) |=> ge_out[0] && le_out[0] && !ne_out[0])
      else $error("compare wrong");
   carry_gen_a: assert property ((mode_in == lsm_pkg::LSM_RIPPLE) &&
      (rop_in == lsm_pkg::LSM_ADD) && (a_in[1:0] == 2'h3) && (b_in[1:0] != 2'h0)
      |=> gen_out[0] && !prop_out[0])
      else $error("carry generate wrong");
   dual_copy_a: assert property (ram_wr && dual_en_in
      |=> st_ff.lut[2][$past(addr_in)] == st_ff.lut[0][$past(addr_in)])
      else $error("companion copy differs");

endmodule

`default_nettype wire

// [lsm_fabric.sv]
`default_nettype none

// ****************************************
// routing fabric: neighbour slices feed operands
// ****************************************
module lsm_fabric (
   // raw routed word
   input  wire logic [31:0] route_in,
   // slice feeds
   output logic      [31:0] lut_in_out,
   output logic      [7:0]  a_out,
   output logic      [7:0]  b_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // plain wires: fabric adds no storage
   assign lut_in_out = route_in;
   assign a_out      = route_in[7:0];
   assign b_out      = route_in[15:8];
endmodule

`default_nettype wire

// [logic_slice_modes_test.sv]
`default_nettype none

module logic_slice_modes_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic               ref_clk_in  = 1'b0;
   logic               resetn_in   = 1'b0;
   lsm_pkg::lsm_mode_t mode_in     = lsm_pkg::LSM_LOGIC;
   lsm_pkg::lsm_rop_t  rop_in      = lsm_pkg::LSM_ADD;
   logic [3:0]         lut5_en_in  = 4'hF;
   logic [3:0]         f5_sel_in   = 4'h0;
   logic [3:0]         addr_in     = 4'h0;
   logic [3:0]         rd_addr_in  = 4'h0;
   logic               dual_en_in  = 1'b0;
   logic               cfg_load_in = 1'b0;
   logic               carry_in    = 1'b0;
   logic               add_nsub_in = 1'b0;
   logic               count_en_in = 1'b0;
   logic               we_in       = 1'b0;
   logic [2:0]         cfg_sel_in  = 3'h0;
   logic [15:0]        cfg_data_in = 16'h0000;
   logic [7:0]         wdata_in    = 8'h00;
   logic [31:0]        route       = 32'h00000000;
   logic [31:0]        rng         = 32'h00000018;
   logic [31:0]        lut_in_in;
   logic [7:0]         a_in, b_in, f_out, fe;
   logic [3:0]         f5_out, gen_out, prop_out, ge_out, ne_out, le_out, f5e;
   logic [3:0]         gn, pr, cge, cne, cle;
   logic [7:0]         lo_f_out;
   logic [1:0]         x, y;
   logic               cout_out, c, sub;
   logic [15:0]        tbl [8];
   logic [15:0]        tbl0 [8];
   logic [44:0]        q [$];
   int                 n_mismatch = 0;
   int                 checks     = 0;

   // ****************************************
   // clock, fabric and unit
   // ****************************************
   initial
   begin
      forever #5 ref_clk_in = ~ref_clk_in;
   end

   lsm_fabric i_lsm_fabric (.route_in(route), .lut_in_out(lut_in_in), .a_out(a_in),
      .b_out(b_in));

   lsm_function_unit i_lsm_function_unit (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
      .mode_in(mode_in), .rop_in(rop_in), .lut5_en_in(lut5_en_in), .dual_en_in(dual_en_in),
      .cfg_load_in(cfg_load_in), .cfg_sel_in(cfg_sel_in), .cfg_data_in(cfg_data_in),
      .lut_in_in(lut_in_in), .f5_sel_in(f5_sel_in), .a_in(a_in), .b_in(b_in),
      .carry_in(carry_in), .add_nsub_in(add_nsub_in), .count_en_in(count_en_in),
      .we_in(we_in), .addr_in(addr_in), .rd_addr_in(rd_addr_in), .wdata_in(wdata_in),
      .f_out(f_out), .f5_out(f5_out), .gen_out(gen_out), .prop_out(prop_out),
      .cout_out(cout_out), .ge_out(ge_out), .ne_out(ne_out), .le_out(le_out));

   // logic-only twin: same stimulus, must never take a data write
   lsm_function_unit #(.RAM_CAPABLE(1'b0)) i_lsm_function_unit_lo (.ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in), .mode_in(mode_in), .rop_in(rop_in), .lut5_en_in(lut5_en_in),
      .dual_en_in(dual_en_in), .cfg_load_in(cfg_load_in), .cfg_sel_in(cfg_sel_in),
      .cfg_data_in(cfg_data_in), .lut_in_in(lut_in_in), .f5_sel_in(f5_sel_in), .a_in(a_in),
      .b_in(b_in), .carry_in(carry_in), .add_nsub_in(add_nsub_in), .count_en_in(count_en_in),
      .we_in(we_in), .addr_in(addr_in), .rd_addr_in(rd_addr_in), .wdata_in(wdata_in),
      .f_out(lo_f_out), .f5_out(), .gen_out(), .prop_out(), .cout_out(), .ge_out(), .ne_out(),
      .le_out());

   // ****************************************
   // helpers
   // ****************************************
   function automatic void rnd();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
   endfunction

   task automatic check(input logic [19:0] seen, input logic [19:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   // note: [44:37] logic-only f, [36] check flags, [35:16] gen prop ge ne le,
   // [15] valid, [14] check f5, [13] check carry, [12] carry, [11:8] f5, [7:0] f
   task automatic step(input logic [44:0] n);
      q.push_back(n);
      @(negedge ref_clk_in);
   endtask

   // odd slices in dual mode read the even partner's contents at rd_addr
   function automatic logic [44:0] ram(input logic [3:0] a, input logic [3:0] r,
      input logic d);
      logic [7:0] v;
      logic [7:0] lo;
      for (int k = 0; k < 8; k++)
      begin
         v[k] = (d && k[1]) ? tbl[k-2][r] : tbl[k][a];
         // logic-only unit keeps its configured tables, odd slices read their own
         lo[k] = tbl0[k][(d && k[1]) ? r : a];
      end
      return {lo, 21'h000000, 8'h80, v};
   endfunction

   task automatic test_done();
      if (n_mismatch == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // results land one edge after the inputs were taken
   always @(posedge ref_clk_in)
   begin
      logic [44:0] e;
      logic [19:0] got;
      logic [19:0] want;
      #1;
      if (q.size() > 0)
      begin
         e = q.pop_front();
         got = {7'h00, e[13] & cout_out, e[14] ? f5_out : 4'h0, f_out};
         want = {7'h00, e[13] & e[12], e[14] ? e[11:8] : 4'h0, e[7:0]};
         if (e[15])
         begin
            check(got, want);
            check({12'h000, lo_f_out}, {12'h000, e[44:37]});
         end
         if (e[36])
            check({gen_out, prop_out, ge_out, ne_out, le_out}, e[35:16]);
      end
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      repeat (6) @(negedge ref_clk_in);
      resetn_in = 1'b1;
      cfg_load_in = 1'b1;
      for (int k = 0; k < 8; k++)
      begin
         rnd();
         tbl[k] = rng[15:0];
         tbl0[k] = rng[15:0];
         cfg_sel_in = 3'(k);
         cfg_data_in = rng[15:0];
         step(45'h0);
      end
      cfg_load_in = 1'b0;
      for (int i = 0; i < 24; i++)
      begin
         rnd();
         route = rng;
         f5_sel_in = rng[31:28];
         lut5_en_in = rng[27:24];
         for (int k = 0; k < 8; k++)
            fe[k] = tbl[k][route[4*k+:4]];
         for (int s = 0; s < 4; s++)
            f5e[s] = lut5_en_in[s] & tbl[2*s + int'(f5_sel_in[s])][route[8*s+:4]];
         step({fe, 21'h000000, 4'hC, f5e, fe});
      end
      mode_in = lsm_pkg::LSM_RIPPLE;
      for (int i = 0; i < 30; i++)
      begin
         rnd();
         route = rng;
         rop_in = (i % 4 == 3) ? lsm_pkg::LSM_CMP : lsm_pkg::lsm_rop_t'(i % 4);
         carry_in = rng[16];
         add_nsub_in = rng[17];
         sub = !(rop_in == lsm_pkg::LSM_ADD || (rop_in == lsm_pkg::LSM_ADDSUB && add_nsub_in));
         // operands from the routed word: the fabric wires settle only later in this step
         if (!sub)
            {c, fe} = {1'b0, route[7:0]} + {1'b0, route[15:8]} + 9'(carry_in);
         else
            {c, fe} = {1'b0, route[7:0]} + {1'b0, ~route[15:8]} + 9'h001;
         for (int s = 0; s < 4; s++)
         begin
            x = route[2*s +: 2];
            y = sub ? ~route[8+2*s +: 2] : route[8+2*s +: 2];
            gn[s] = ({1'b0, x} + {1'b0, y}) > 3'h3;
            pr[s] = (x ^ y) == 2'h3;
            cge[s] = route[2*s +: 2] >= route[8+2*s +: 2];
            cne[s] = route[2*s +: 2] != route[8+2*s +: 2];
            cle[s] = route[2*s +: 2] <= route[8+2*s +: 2];
         end
         step({fe, 1'b1, gn, pr, cge, cne, cle, 3'b101, c, 4'h0, fe});
      end
      count_en_in = 1'b1;
      rop_in = lsm_pkg::LSM_UP;
      for (int i = 1; i < 4; i++)
         step({8'(i), 21'h000000, 8'h80, 8'(i)});
      rop_in = lsm_pkg::LSM_DOWN;
      for (int i = 2; i > -2; i--)
         step({8'(i), 21'h000000, 8'h80, 8'(i)});
      count_en_in = 1'b0;
      step({8'hFF, 21'h000000, 16'h80FF});
      mode_in = lsm_pkg::LSM_RAM;
      we_in = 1'b1;
      for (int w = 0; w < 16; w++)
      begin
         rnd();
         addr_in = 4'(w);
         wdata_in = rng[7:0];
         step(ram(addr_in, 4'h0, 1'b0));
         for (int k = 0; k < 8; k++)
            tbl[k][w] = wdata_in[k];
      end
      // ROM: write attempts must leave contents alone
      mode_in = lsm_pkg::LSM_ROM;
      for (int w = 0; w < 16; w++)
      begin
         rnd();
         addr_in = 4'(15 - w);
         wdata_in = rng[7:0];
         step(ram(addr_in, 4'h0, 1'b0));
      end
      mode_in = lsm_pkg::LSM_RAM;
      dual_en_in = 1'b1;
      // both copies of a pair must be written before the read-only port is trusted
      for (int w = 0; w < 16; w++)
      begin
         rnd();
         addr_in = 4'(w);
         rd_addr_in = rng[11:8];
         wdata_in = rng[7:0];
         step(45'h0);
         for (int k = 0; k < 8; k++)
            tbl[k][w] = wdata_in[k & ~2];
      end
      we_in = 1'b0;
      for (int i = 0; i < 12; i++)
      begin
         rnd();
         addr_in = rng[3:0];
         rd_addr_in = rng[7:4];
         step(ram(addr_in, rd_addr_in, 1'b1));
      end
      for (int i = 0; i < 10 && q.size() > 0; i++)
         @(negedge ref_clk_in);
      if (q.size() > 0)
         n_mismatch++;
      test_done();
   end
endmodule

`default_nettype wire
